// ### hw/asrq_defs.vh
// Purpose: Register offsets, field positions and reset values of the sync and requantizer block.
// Assumes: Byte-wide registers at the offsets listed below.
// Notes:   Definitions only.
`ifndef ASRQ_DEFS_VH
`define ASRQ_DEFS_VH
`define ASRQ_ADDR_CHAN_IDX    8'h05
`define ASRQ_ADDR_SIG_LO      8'h24
`define ASRQ_ADDR_SIG_HI      8'h25
`define ASRQ_ADDR_ALIGN       8'h3A
`define ASRQ_ADDR_NSQ_CTRL    8'h3C
`define ASRQ_ADDR_BAND        8'h3E
`define ASRQ_BIT_MASTER_SYNC  0
`define ASRQ_BIT_DIV_SYNC     1
`define ASRQ_BIT_NSQ_EN       0
`define ASRQ_MODE_LSB         1
`define ASRQ_MODE_MSB         3
`define ASRQ_BIT_PIN_OVR      4
`define ASRQ_BAND_MSB         5
`define ASRQ_RST_ALIGN        8'h00
`define ASRQ_RST_NSQ_CTRL     8'h00
`define ASRQ_RST_BAND         8'h1C
`define ASRQ_RST_CHAN_IDX     8'h03
`define ASRQ_MODE_NARROW      3'h0
`define ASRQ_MODE_WIDE        3'h1
`define ASRQ_BAND_MAX_NARROW  6'h38
`define ASRQ_BAND_MAX_WIDE    6'h21
`endif

// ### hw/asrq_ctrl.v
// Purpose: Sync gating, requantizer control, band tuning word and self-check signature read.
// Assumes: Register port is already in the clk domain; sync pulse and mode pin are raw pins.
// Notes:   Two channels; local registers are held per channel.
`include "asrq_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module asrq_ctrl
#(
  parameter NCH = 2
)
(
  input  wire             clk,
  input  wire             rst_n,
  input  wire             reg_wr,
  input  wire             reg_rd,
  input  wire [7:0]       reg_addr,
  input  wire [7:0]       reg_wdata,
  output reg  [7:0]       reg_rdata,
  input  wire [16*NCH-1:0] self_check_sig,
  input  wire             sync_pin,
  input  wire             mode_pin,
  output reg              div_resync,
  output reg  [NCH-1:0]   nsq_active,
  output reg  [NCH-1:0]   nsq_wide,
  output reg  [6*NCH-1:0] nsq_band_word,
  output reg  [NCH-1:0]   nsq_band_legal
);

  // ==========================================================================
  // Pin synchronisers and sync edge
  // ==========================================================================
  reg sync_m_r;
  reg sync_s_r;
  reg sync_d_r;
  reg mode_m_r;
  reg mode_s_r;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_m_r <= 1'b0;
      sync_s_r <= 1'b0;
      sync_d_r <= 1'b0;
      mode_m_r <= 1'b0;
      mode_s_r <= 1'b0;
    end
    else
    begin
      sync_m_r <= sync_pin;
      sync_s_r <= sync_m_r;
      sync_d_r <= sync_s_r;
      mode_m_r <= mode_pin;
      mode_s_r <= mode_m_r;
    end
  end

  wire sync_rise = sync_s_r & ~sync_d_r;

  // ==========================================================================
  // Global registers
  // ==========================================================================
  reg [7:0] chan_idx_r;
  reg [1:0] align_r;
  // Full-width reset constants, cut on purpose to the stored widths below.
  wire [7:0] rst_align = `ASRQ_RST_ALIGN;
  wire [7:0] rst_ctrl  = `ASRQ_RST_NSQ_CTRL;
  wire [7:0] rst_band  = `ASRQ_RST_BAND;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      chan_idx_r <= `ASRQ_RST_CHAN_IDX;
      align_r    <= rst_align[1:0];
    end
    else if (reg_wr)
    begin
      if (reg_addr == `ASRQ_ADDR_CHAN_IDX)
        chan_idx_r <= reg_wdata;
      if (reg_addr == `ASRQ_ADDR_ALIGN)
        align_r <= reg_wdata[1:0];
    end
  end

  wire master_on = align_r[`ASRQ_BIT_MASTER_SYNC];
  wire div_on    = align_r[`ASRQ_BIT_DIV_SYNC];

  always @(posedge clk)
  begin
    if (!rst_n)
      div_resync <= 1'b0;
    else
      div_resync <= sync_rise & master_on & div_on;
  end

  // ==========================================================================
  // Per-channel local registers and requantizer control
  // ==========================================================================
  reg [4:0] ctrl_r [0:NCH-1];
  reg [5:0] band_r [0:NCH-1];
  integer   i;
  integer   j;
  integer   k;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        ctrl_r[i] <= rst_ctrl[4:0];
        band_r[i] <= rst_band[5:0];
      end
    end
    else if (reg_wr)
    begin
      for (i = 0; i < NCH; i = i + 1)
      begin
        if (chan_idx_r[i])
        begin
          if (reg_addr == `ASRQ_ADDR_NSQ_CTRL)
            ctrl_r[i] <= reg_wdata[4:0];
          if (reg_addr == `ASRQ_ADDR_BAND)
            band_r[i] <= reg_wdata[`ASRQ_BAND_MSB:0];
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      nsq_active     <= {NCH{1'b0}};
      nsq_wide       <= {NCH{1'b0}};
      nsq_band_word  <= {6*NCH{1'b0}};
      nsq_band_legal <= {NCH{1'b0}};
    end
    else
    begin
      for (j = 0; j < NCH; j = j + 1)
      begin
        // Pin decides unless overridden; register enable counts only under override.
        nsq_active[j] <= ctrl_r[j][`ASRQ_BIT_PIN_OVR] ?
                         ctrl_r[j][`ASRQ_BIT_NSQ_EN] : mode_s_r;
        nsq_wide[j]   <= (ctrl_r[j][`ASRQ_MODE_MSB:`ASRQ_MODE_LSB] == `ASRQ_MODE_WIDE);
        // Each word step is one half percent of the sample rate downstream.
        nsq_band_word[6*j +: 6] <= band_r[j];
        if (ctrl_r[j][`ASRQ_MODE_MSB:`ASRQ_MODE_LSB] == `ASRQ_MODE_NARROW)
          nsq_band_legal[j] <= (band_r[j] <= `ASRQ_BAND_MAX_NARROW);
        else if (ctrl_r[j][`ASRQ_MODE_MSB:`ASRQ_MODE_LSB] == `ASRQ_MODE_WIDE)
          nsq_band_legal[j] <= (band_r[j] <= `ASRQ_BAND_MAX_WIDE);
        else
          nsq_band_legal[j] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read back
  // ==========================================================================
  reg [7:0] rd_nxt;
  reg [7:0] loc_ctrl_v;
  reg [7:0] loc_band_v;
  reg [15:0] loc_sig_v;
  reg        found_v;

  always @*
  begin
    loc_ctrl_v = 8'h00;
    loc_band_v = 8'h00;
    loc_sig_v  = 16'h0000;
    found_v    = 1'b0;
    // Reading with several channels chosen returns the lowest chosen one.
    for (k = NCH - 1; k >= 0; k = k - 1)
    begin
      if (chan_idx_r[k])
      begin
        loc_ctrl_v = {3'h0, ctrl_r[k]};
        loc_band_v = {2'h0, band_r[k]};
        loc_sig_v  = self_check_sig[16*k +: 16];
        found_v    = 1'b1;
      end
    end
    case (reg_addr)
      `ASRQ_ADDR_CHAN_IDX: rd_nxt = chan_idx_r;
      `ASRQ_ADDR_SIG_LO:   rd_nxt = loc_sig_v[7:0];
      `ASRQ_ADDR_SIG_HI:   rd_nxt = loc_sig_v[15:8];
      `ASRQ_ADDR_ALIGN:    rd_nxt = {6'h00, align_r};
      `ASRQ_ADDR_NSQ_CTRL: rd_nxt = loc_ctrl_v;
      `ASRQ_ADDR_BAND:     rd_nxt = loc_band_v;
      default:             rd_nxt = 8'h00;
    endcase
    if (!found_v && reg_addr != `ASRQ_ADDR_CHAN_IDX && reg_addr != `ASRQ_ADDR_ALIGN)
      rd_nxt = 8'h00;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_nxt;
  end

endmodule // asrq_ctrl

`default_nettype wire

// ### dv/asrq_ctrl_props.sv
// Purpose: Port assertions for asrq_ctrl.
// Assumes: One clk domain with a synchronous active-low reset.
// Notes:   h_r mirrors the alignment bits and any override write.
`timescale 1ns/100ps
`default_nettype none
module asrq_ctrl_props #(parameter NCH = 2)
(
  input wire clk, rst_n, reg_wr, reg_rd, sync_pin, mode_pin, div_resync,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire [16*NCH-1:0] self_check_sig,
  input wire [NCH-1:0] nsq_active, nsq_wide, nsq_band_legal,
  input wire [6*NCH-1:0] nsq_band_word
);
  reg [2:0] h_r;
  always @(posedge clk)
    if (!rst_n)
      h_r <= 3'h0;
    else if (reg_wr && reg_addr == 8'h3A)
      h_r[1:0] <= reg_wdata[1:0];
    else if (reg_wr && reg_addr == 8'h3C && reg_wdata[4])
      h_r[2] <= 1'b1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    $rose(sync_pin) && h_r[1:0] == 2'h3;
  endsequence
  sequence s_steady;
    $stable(mode_pin)[*4] ##0 (!h_r[2] && $past(rst_n, 4));
  endsequence
  a_sync_gate: assert property (div_resync |-> h_r[1:0] == 2'h3)
    else $error("resync while gated");
  a_sync_follow: assert property (s_rise |-> ##3 div_resync)
    else $error("resync missing");
  a_sync_single: assert property (div_resync |=> !div_resync)
    else $error("resync too long");
  a_pin_rules: assert property (s_steady |-> nsq_active == {NCH{mode_pin}})
    else $error("pin control lost");
  a_narrow_legal: assert property (nsq_band_legal[0] |-> nsq_band_word[5:0] <= 6'h38)
    else $error("legal flag too wide");
  a_wide_legal: assert property (nsq_wide[0] |-> nsq_band_legal[0] == (nsq_band_word[5:0] <= 6'h21))
    else $error("wide legal flag");
  a_band_rsvd: assert property (reg_rd && reg_addr == 8'h3E |=> reg_rdata[7:6] == 2'h0)
    else $error("band reserved bits");
  a_align_rsvd: assert property (reg_rd && reg_addr == 8'h3A |=> reg_rdata[7:2] == 6'h00)
    else $error("align reserved bits");
endmodule // asrq_ctrl_props
bind asrq_ctrl asrq_ctrl_props #(.NCH(NCH)) u_props (.clk, .rst_n, .reg_wr, .reg_rd, .sync_pin,
  .mode_pin, .div_resync, .reg_addr, .reg_wdata, .reg_rdata, .self_check_sig, .nsq_active,
  .nsq_wide, .nsq_band_legal, .nsq_band_word);
`default_nettype wire

// ### dv/asrq_ctrl_test.sv
// Purpose: Self-checking bench for asrq_ctrl.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Per-channel register model; LFSR seeded with 67.
`timescale 1ns/100ps
`default_nettype none
module asrq_ctrl_test;
  reg         clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sync_pin = 0, mode_pin = 0;
  reg  [7:0]  reg_addr = 0, reg_wdata = 0, lf = 8'h43, ch = 8'h03, al = 0, ctl [0:1], band [0:1];
  reg  [31:0] self_check_sig = 0;
  reg  [17:0] e;
  wire [7:0]  reg_rdata;
  wire        div_resync;
  wire [1:0]  nsq_active, nsq_wide, nsq_band_legal;
  wire [11:0] nsq_band_word;
  integer     err_count = 0, compares = 0, i, k, n;
  asrq_ctrl dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .self_check_sig, .sync_pin, .mode_pin, .div_resync, .nsq_active, .nsq_wide,
    .nsq_band_word, .nsq_band_legal);
  always #10 clk = ~clk;
  // ==========
  // Tasks
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task chk(input [47:0] nm, input [17:0] ex, input [17:0] got);
  begin
    compares = compares + 1;
    if (got !== ex)
    begin
      err_count = err_count + 1;
      $display("mismatch %0s exp %h seen %h", nm, ex, got);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    if (a == 8'h05) ch = d;
    if (a == 8'h3A) al = d & 8'h03;
    for (k = 0; k < 2; k = k + 1)
      if (ch[k] && a == 8'h3C) ctl[k] = d & 8'h1F;
      else if (ch[k] && a == 8'h3E) band[k] = d & 8'h3F;
  end
  endtask
  task rdc(input [7:0] a);
  begin
    @(posedge clk) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    n = ch[0] ? 0 : 16;
    chk("rdata", a == 8'h3A ? al : a == 8'h05 ? ch : ch[1:0] == 0 ? 0 : a == 8'h3C ? ctl[n/16]
      : a == 8'h3E ? band[n/16] : a == 8'h24 ? self_check_sig[n+:8]
      : a == 8'h25 ? self_check_sig[n+8+:8] : 0, reg_rdata);
  end
  endtask
  task ochk;
  begin
    @(posedge clk) #1;
    for (k = 0; k < 2; k = k + 1)
    begin
      e[16 + k] = ctl[k][4] ? ctl[k][0] : mode_pin;
      e[14 + k] = ctl[k][3:1] == 1;
      e[12 + k] = ctl[k][3:1] == 0 ? band[k] < 57 : e[14 + k] && band[k] < 34;
      e[6 * k +: 6] = band[k];
    end
    chk("outs", e, {nsq_active, nsq_wide, nsq_band_legal, nsq_band_word});
  end
  endtask
  task sy(input [7:0] a);
  begin
    wr(8'h3A, a);
    @(posedge clk) #1;
    sync_pin = 1'b1;
    n = 0;
    repeat (8) @(posedge clk) #1 n = n + div_resync;
    sync_pin = 1'b0;
    repeat (3) @(posedge clk) #1;
    chk("resync", a == 8'h03, n);
  end
  endtask
  task test_done;
  begin
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  initial
  begin
    for (k = 0; k < 2; k = k + 1)
    begin
      ctl[k] = 8'h00;
      band[k] = 8'h1C;
    end
    repeat (12) @(posedge clk) #1;
    rst_n = 1'b1;
    for (i = 0; i < 7; i = i + 1) rdc(56'h05_24_25_3A_3C_3E_40 >> (8 * i));
    ochk;
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) sy(i);
    wr(8'h3A, 8'h00);
    $display("sync test done");
    mode_pin = 1'b1;
    repeat (4) @(posedge clk) #1;
    ochk;
    wr(8'h3C, 8'h01);
    mode_pin = 1'b0;
    repeat (4) @(posedge clk) #1;
    ochk;
    wr(8'h05, 8'h01);
    wr(8'h3C, 8'h11);
    wr(8'h05, 8'h02);
    wr(8'h3C, 8'h12);
    wr(8'h05, 8'h00);
    wr(8'h3E, 8'h05);
    rdc(8'h3C);
    ochk;
    $display("channel test done");
    wr(8'h05, 8'h03);
    for (i = 0; i < 16; i = i + 1)
    begin
      lf = nx(lf);
      wr(8'h3C, 8'h10 | ((i < 4 ? i / 2 : i % 8) << 1) | lf[0]);
      wr(8'h3E, i < 4 ? 32'h22213938 >> (8 * i) : lf);
      rdc(8'h3E);
      ochk;
    end
    $display("band test done");
    self_check_sig = {lf, ~lf, nx(lf), 8'hA5};
    wr(8'h24, 8'hFF);
    for (i = 0; i < 4; i = i + 1)
    begin
      if (i == 2) wr(8'h05, 8'h02);
      rdc(8'h24 + i % 2);
    end
    $display("signature test done");
    test_done;
  end
endmodule // asrq_ctrl_test
`default_nettype wire
